// *** bpm_pkg.sv ***
package bpm_pkg;

   // Clock and time base
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_NS       = 1000;
   localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Periodic sampling of the voltage comparators
   localparam int SAMPLE_PERIOD_MS    = 125;
   localparam int SAMPLE_ON_MS        = 2;
   localparam int SAMPLE_PERIOD_TICKS = SAMPLE_PERIOD_MS * 1000000 / TICK_NS;
   localparam int SAMPLE_ON_TICKS     = SAMPLE_ON_MS * 1000000 / TICK_NS;

   // Delay scaling; delay settings are in units of 1 nF
   localparam int DETECT_S_PER_UF     = 10;
   localparam int RELEASE_MS_PER_UF   = 70;
   localparam int DETECT_TICKS_PER_NF  = DETECT_S_PER_UF * 1000000 / TICK_NS;
   localparam int RELEASE_TICKS_PER_NF = RELEASE_MS_PER_UF * 1000 / TICK_NS;
   localparam int OC_TICKS_PER_NF      = 1;

   // Register map
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CFG    = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;

   localparam logic [1:0] CTRL_RESET = 2'h3;
   localparam logic [6:0] CFG_RESET  = 7'h00;

   localparam int CTRL_CHG_BIT       = 0;
   localparam int CTRL_DIS_BIT       = 1;
   localparam int CFG_OV_LSB         = 0;
   localparam int CFG_UV_LSB         = 2;
   localparam int CFG_OC_LSB         = 4;
   localparam int CFG_CHG_EN_DIS_BIT = 6;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {REG_CTRL, REG_CFG, REG_STATUS, REG_NONE} reg_sel_e;

   typedef enum logic [2:0] {OD_NORMAL, OD_SLEEP, OD_WAIT_CHG, OD_RELEASE, OD_WAIT_DIS} od_state_e;

endpackage

// *** sample_scheduler.sv ***
module sample_scheduler import bpm_pkg::*; #(
   parameter int TICK_CYC = TICK_CYCLES,
   parameter int PERIOD   = SAMPLE_PERIOD_TICKS,
   parameter int ON_TIME  = SAMPLE_ON_TICKS
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   output logic      tick_o,
   output logic      window_o
);

   logic [15:0] pre_q;
   logic [31:0] slot_q;
   wire         pre_end  = (pre_q == 16'(TICK_CYC - 1));
   wire         slot_end = (slot_q == 32'(PERIOD - 1));

   // Microsecond tick and the on-slot at the head of each period
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pre_q    <= '0;
         slot_q   <= '0;
         tick_o   <= 1'b0;
         window_o <= 1'b0;
      end else begin
         pre_q    <= pre_end ? '0 : pre_q + 16'h1;
         tick_o   <= pre_end;
         if (pre_end) begin
            slot_q <= slot_end ? '0 : slot_q + 32'h1;
         end
         window_o <= (slot_q < 32'(ON_TIME));
      end
   end

endmodule

// *** delay_timer.sv ***
module delay_timer import bpm_pkg::*; (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        tick_i,
   input  wire logic        run_i,
   input  wire logic [31:0] limit_i,
   output logic             expired_o
);

   logic [31:0] count_q;
   wire  [31:0] count_inc = count_q + 32'h1;

   // Dropping run cancels the count at once
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !run_i) begin
         count_q   <= '0;
         expired_o <= 1'b0;
      end else if (tick_i && !expired_o) begin
         count_q   <= count_inc;
         expired_o <= (count_inc >= limit_i);
      end
   end

endmodule

// *** battery_protection_mode_controller.sv ***
// Chosen here: register access over AXI4-Lite and the register addresses.
module battery_protection_mode_controller import bpm_pkg::*; #(
   parameter int ADDR_W       = 8,
   parameter int SET_W        = 8,
   parameter int PERIOD_TICKS = SAMPLE_PERIOD_TICKS,
   parameter int ON_TICKS     = SAMPLE_ON_TICKS,
   parameter int DETECT_PER_NF  = DETECT_TICKS_PER_NF,
   parameter int RELEASE_PER_NF = RELEASE_TICKS_PER_NF,
   parameter int OC_PER_NF      = OC_TICKS_PER_NF
) (
   input  wire logic              REF_CLK_I,
   input  wire logic              RESET_N_I,
   input  wire logic [2:0]        ANALOG_SEL_I,
   input  wire logic              CELL_OVER_CHARGE_I,
   input  wire logic              CELL_BELOW_OV_RELEASE_I,
   input  wire logic              CELL_UNDER_DISCHARGE_I,
   input  wire logic              CELL_ABOVE_UV_RELEASE_I,
   input  wire logic              CELL_CHARGE_LOW_I,
   input  wire logic              OVERCURRENT_I,
   input  wire logic              REG_UNTUNED_I,
   input  wire logic              WAKE_I,
   input  wire logic [SET_W-1:0]  OVERCHARGE_DELAY_SET_I,
   input  wire logic [SET_W-1:0]  OVERDISCHARGE_DELAY_SET_I,
   input  wire logic [SET_W-1:0]  OVERCURRENT_DELAY_SET_I,
   output logic                   CHARGE_FET_DRIVE_O,
   output logic                   DISCHARGE_FET_DRIVE_O,
   output logic                   COMPARATOR_EN_O,
   output logic                   SLEEP_O,
   output logic [1:0]             OVERCHARGE_THRESH_SEL_O,
   output logic [1:0]             OVERDISCHARGE_THRESH_SEL_O,
   output logic [1:0]             OVERCURRENT_THRESH_SEL_O,
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
   input  wire logic              S_AXI_AWVALID_I,
   output logic                   S_AXI_AWREADY_O,
   input  wire logic [31:0]       S_AXI_WDATA_I,
   input  wire logic [3:0]        S_AXI_WSTRB_I,
   input  wire logic              S_AXI_WVALID_I,
   output logic                   S_AXI_WREADY_O,
   output logic [1:0]             S_AXI_BRESP_O,
   output logic                   S_AXI_BVALID_O,
   input  wire logic              S_AXI_BREADY_I,
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
   input  wire logic              S_AXI_ARVALID_I,
   output logic                   S_AXI_ARREADY_O,
   output logic [31:0]            S_AXI_RDATA_O,
   output logic [1:0]             S_AXI_RRESP_O,
   output logic                   S_AXI_RVALID_O,
   input  wire logic              S_AXI_RREADY_I
);

   function automatic reg_sel_e reg_decode(input logic [ADDR_W-1:0] addr);
      if (addr == ADDR_W'(ADDR_CTRL)) begin
         return REG_CTRL;
      end else if (addr == ADDR_W'(ADDR_CFG)) begin
         return REG_CFG;
      end else if (addr == ADDR_W'(ADDR_STATUS)) begin
         return REG_STATUS;
      end else begin
         return REG_NONE;
      end
   endfunction

   // ---------------- Register bus slave ----------------
   logic              aw_have_q;
   logic              w_have_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [7:0]        wdata_q;
   logic              wstrb0_q;
   logic [1:0]        chg_dis_ctl_q;
   logic [6:0]        cfg_q;
   logic [7:0]        status_q;

   wire aw_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
   wire w_take  = S_AXI_WVALID_I && S_AXI_WREADY_O;
   wire b_done  = S_AXI_BVALID_O && S_AXI_BREADY_I;
   wire ar_take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
   wire r_done  = S_AXI_RVALID_O && S_AXI_RREADY_I;

   wire      wr_fire = aw_have_q && w_have_q && !S_AXI_BVALID_O;
   reg_sel_e wr_sel;
   reg_sel_e rd_sel;
   assign wr_sel = reg_decode(awaddr_q);
   assign rd_sel = reg_decode(S_AXI_ARADDR_I);

   wire wr_ok   = (wr_sel == REG_CTRL) || (wr_sel == REG_CFG);
   wire wr_ctrl = wr_fire && wstrb0_q && (wr_sel == REG_CTRL);
   wire wr_cfg  = wr_fire && wstrb0_q && (wr_sel == REG_CFG);

   wire [7:0] rd_byte = (rd_sel == REG_CTRL)   ? {6'h00, chg_dis_ctl_q} :
                        (rd_sel == REG_CFG)    ? {1'b0, cfg_q} :
                        (rd_sel == REG_STATUS) ? status_q : 8'h00;

   always_ff @(posedge REF_CLK_I) begin
      if (!RESET_N_I) begin
         S_AXI_AWREADY_O <= 1'b1;
         S_AXI_WREADY_O  <= 1'b1;
         aw_have_q       <= 1'b0;
         w_have_q        <= 1'b0;
         awaddr_q        <= '0;
         wdata_q         <= 8'h00;
         wstrb0_q        <= 1'b0;
         S_AXI_BVALID_O  <= 1'b0;
         S_AXI_BRESP_O   <= RESP_OKAY;
      end else begin
         if (aw_take) begin
            awaddr_q        <= S_AXI_AWADDR_I;
            aw_have_q       <= 1'b1;
            S_AXI_AWREADY_O <= 1'b0;
         end
         if (w_take) begin
            wdata_q        <= S_AXI_WDATA_I[7:0];
            wstrb0_q       <= S_AXI_WSTRB_I[0];
            w_have_q       <= 1'b1;
            S_AXI_WREADY_O <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_q      <= 1'b0;
            w_have_q       <= 1'b0;
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (b_done) begin
            S_AXI_BVALID_O  <= 1'b0;
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O  <= 1'b1;
         end
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RESET_N_I) begin
         S_AXI_ARREADY_O <= 1'b1;
         S_AXI_RVALID_O  <= 1'b0;
         S_AXI_RDATA_O   <= 32'h0000_0000;
         S_AXI_RRESP_O   <= RESP_OKAY;
      end else if (ar_take) begin
         S_AXI_ARREADY_O <= 1'b0;
         S_AXI_RVALID_O  <= 1'b1;
         S_AXI_RDATA_O   <= {24'h000000, rd_byte};
         S_AXI_RRESP_O   <= (rd_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (r_done) begin
         S_AXI_ARREADY_O <= 1'b1;
         S_AXI_RVALID_O  <= 1'b0;
      end
   end

   // ---------------- Sampling and comparator latches ----------------
   logic      tick;
   logic      window;
   logic      comp_en_q;
   logic      ov_hit_q;
   logic      ov_clear_q;
   logic      uv_hit_q;
   logic      uv_clear_q;
   logic      cce_low_q;
   logic      ov_mode_q;
   logic      oc_mode_q;
   od_state_e od_state_q;
   od_state_e od_state_d;

   sample_scheduler #(
      .TICK_CYC (TICK_CYCLES),
      .PERIOD   (PERIOD_TICKS),
      .ON_TIME  (ON_TICKS)
   ) u_sched (
      .clk_i    (REF_CLK_I),
      .rst_n_i  (RESET_N_I),
      .tick_o   (tick),
      .window_o (window)
   );

   wire monitor_mode = |ANALOG_SEL_I;
   wire comp_en_d    = (od_state_d != OD_SLEEP) && (monitor_mode || window);

   // Readings only follow the comparators while they are powered
   always_ff @(posedge REF_CLK_I) begin
      if (!RESET_N_I) begin
         comp_en_q  <= 1'b0;
         ov_hit_q   <= 1'b0;
         ov_clear_q <= 1'b0;
         uv_hit_q   <= 1'b0;
         uv_clear_q <= 1'b0;
         cce_low_q  <= 1'b0;
      end else begin
         comp_en_q <= comp_en_d;
         if (comp_en_q) begin
            ov_hit_q   <= CELL_OVER_CHARGE_I;
            ov_clear_q <= CELL_BELOW_OV_RELEASE_I;
            uv_hit_q   <= CELL_UNDER_DISCHARGE_I;
            uv_clear_q <= CELL_ABOVE_UV_RELEASE_I;
            cce_low_q  <= CELL_CHARGE_LOW_I;
         end
      end
   end

   // ---------------- Delay timers ----------------
   localparam int NT = 4;
   logic [NT-1:0]    t_run;
   logic [NT-1:0]    t_exp;
   logic [31:0]      t_lim [NT];

   assign t_run[0] = ov_hit_q && !ov_mode_q && (od_state_q != OD_SLEEP);
   assign t_run[1] = uv_hit_q && (od_state_q == OD_NORMAL);
   assign t_run[2] = uv_clear_q && (od_state_q == OD_RELEASE);
   assign t_run[3] = OVERCURRENT_I && !oc_mode_q;
   assign t_lim[0] = 32'(OVERCHARGE_DELAY_SET_I) * 32'(DETECT_PER_NF);
   assign t_lim[1] = 32'(OVERDISCHARGE_DELAY_SET_I) * 32'(DETECT_PER_NF);
   assign t_lim[2] = 32'(OVERDISCHARGE_DELAY_SET_I) * 32'(RELEASE_PER_NF);
   assign t_lim[3] = 32'(OVERCURRENT_DELAY_SET_I) * 32'(OC_PER_NF);

   for (genvar g = 0; g < NT; g++) begin : g_timer
      delay_timer u_timer (
         .clk_i     (REF_CLK_I),
         .rst_n_i   (RESET_N_I),
         .tick_i    (tick),
         .run_i     (t_run[g]),
         .limit_i   (t_lim[g]),
         .expired_o (t_exp[g])
      );
   end

   // ---------------- Protection modes ----------------
   wire ov_enter  = t_exp[0] && ov_hit_q;
   wire ov_leave  = ov_mode_q && ov_clear_q;
   wire ov_mode_d = (ov_mode_q && !ov_leave) || ov_enter;
   wire oc_mode_d = t_exp[3] || (oc_mode_q && OVERCURRENT_I);

   wire chg_set_wr = wr_ctrl && wdata_q[CTRL_CHG_BIT];
   wire dis_set_wr = wr_ctrl && wdata_q[CTRL_DIS_BIT];

   always_comb begin
      od_state_d = od_state_q;
      case (od_state_q)
         OD_NORMAL:   if (t_exp[1] && uv_hit_q) od_state_d = OD_SLEEP;
         OD_SLEEP:    if (WAKE_I) od_state_d = OD_WAIT_CHG;
         OD_WAIT_CHG: if (chg_set_wr) od_state_d = OD_RELEASE;
         OD_RELEASE:  if (t_exp[2]) od_state_d = OD_WAIT_DIS;
         OD_WAIT_DIS: if (dis_set_wr) od_state_d = OD_NORMAL;
         default:     od_state_d = OD_NORMAL;
      endcase
   end

   // Writes land during over-charge; sleep blocks FET control
   wire [1:0] ctl_d = (wr_ctrl && od_state_q != OD_SLEEP) ? wdata_q[1:0] : chg_dis_ctl_q;

   wire od_off   = od_state_d != OD_NORMAL;
   wire chg_hold = (od_state_d == OD_SLEEP) || (od_state_d == OD_WAIT_CHG);
   wire chg_off  = chg_hold || ov_mode_d || !ctl_d[CTRL_CHG_BIT];
   wire dis_off  = od_off || oc_mode_d || !ctl_d[CTRL_DIS_BIT];

   wire       charge_enable_disable_bit = cfg_q[CFG_CHG_EN_DIS_BIT];
   wire [7:0] status_d = {5'h00,
                          ov_mode_q || (cce_low_q && !charge_enable_disable_bit),
                          od_state_q != OD_NORMAL,
                          oc_mode_q || REG_UNTUNED_I};

   always_ff @(posedge REF_CLK_I) begin
      if (!RESET_N_I) begin
         od_state_q            <= OD_NORMAL;
         ov_mode_q             <= 1'b0;
         oc_mode_q             <= 1'b0;
         chg_dis_ctl_q         <= CTRL_RESET;
         cfg_q                 <= CFG_RESET;
         status_q              <= 8'h00;
         CHARGE_FET_DRIVE_O    <= !CTRL_RESET[CTRL_CHG_BIT];
         DISCHARGE_FET_DRIVE_O <= !CTRL_RESET[CTRL_DIS_BIT];
         SLEEP_O               <= 1'b0;
      end else begin
         od_state_q            <= od_state_d;
         ov_mode_q             <= ov_mode_d;
         oc_mode_q             <= oc_mode_d;
         chg_dis_ctl_q         <= ctl_d;
         status_q              <= status_d;
         CHARGE_FET_DRIVE_O    <= chg_off;
         DISCHARGE_FET_DRIVE_O <= dis_off;
         SLEEP_O               <= (od_state_d == OD_SLEEP);
         if (wr_cfg) begin
            cfg_q <= wdata_q[6:0];
         end
      end
   end

   assign COMPARATOR_EN_O            = comp_en_q;
   assign OVERCHARGE_THRESH_SEL_O    = cfg_q[CFG_OV_LSB +: 2];
   assign OVERDISCHARGE_THRESH_SEL_O = cfg_q[CFG_UV_LSB +: 2];
   assign OVERCURRENT_THRESH_SEL_O   = cfg_q[CFG_OC_LSB +: 2];

   // ---------------- Assertions ----------------
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RESET_N_I);

   property p_comp_idle;
      !monitor_mode && !window |=> !COMPARATOR_EN_O;
   endproperty
   a_comp_idle: assert property (p_comp_idle) else $error("comparators powered outside slot");
   property p_comp_monitor;
      monitor_mode && od_state_d != OD_SLEEP |=> COMPARATOR_EN_O;
   endproperty
   a_comp_monitor: assert property (p_comp_monitor) else $error("monitor not continuous");
   property p_ov_needs_hit;
      $rose(ov_mode_q) |-> $past(ov_hit_q) && $past(t_exp[0]);
   endproperty
   a_ov_needs_hit: assert property (p_ov_needs_hit) else $error("over-charge entered early");
   property p_ov_off;
      ov_mode_q |-> CHARGE_FET_DRIVE_O;
   endproperty
   a_ov_off: assert property (p_ov_off) else $error("charge FET on in over-charge");
   property p_ov_release;
      $fell(ov_mode_q) && chg_dis_ctl_q[CTRL_CHG_BIT] && od_state_q == OD_NORMAL |-> !CHARGE_FET_DRIVE_O;
   endproperty
   a_ov_release: assert property (p_ov_release) else $error("charge FET not restored");
   property p_ov_keeps_dis;
      $rose(ov_mode_q) && od_state_q == OD_NORMAL && $stable(od_state_q) && $stable(oc_mode_q)
         && $stable(chg_dis_ctl_q) |-> $stable(DISCHARGE_FET_DRIVE_O);
   endproperty
   a_ov_keeps_dis: assert property (p_ov_keeps_dis) else $error("discharge FET disturbed");
   property p_sleep_off;
      od_state_q == OD_SLEEP |-> CHARGE_FET_DRIVE_O && DISCHARGE_FET_DRIVE_O && SLEEP_O;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("FET on during sleep");
   property p_wait_chg;
      od_state_q == OD_WAIT_CHG |-> DISCHARGE_FET_DRIVE_O ##1 (od_state_q != OD_NORMAL);
   endproperty
   a_wait_chg: assert property (p_wait_chg) else $error("discharge early after wake");
   property p_fet_ctl;
      od_state_q == OD_NORMAL && !ov_mode_q && !oc_mode_q
         |-> CHARGE_FET_DRIVE_O == !chg_dis_ctl_q[CTRL_CHG_BIT]
          && DISCHARGE_FET_DRIVE_O == !chg_dis_ctl_q[CTRL_DIS_BIT];
   endproperty
   a_fet_ctl: assert property (p_fet_ctl) else $error("FET drive not following control");
   property p_status;
      1'b1 |=> status_q[7:3] == 5'h00 && status_q[1] == $past(od_state_q != OD_NORMAL);
   endproperty
   a_status: assert property (p_status) else $error("status byte wrong");
   property p_cancel;
      !ov_hit_q |=> !t_exp[0];
   endproperty
   a_cancel: assert property (p_cancel) else $error("timer not cancelled");
   c_ov_mode: cover property ($rose(ov_mode_q));
   c_sleep:   cover property (od_state_q == OD_SLEEP);
   c_recover: cover property (od_state_q == OD_WAIT_DIS ##1 od_state_q == OD_NORMAL);
   c_write:   cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);

endmodule

// *** cell_comparator_model.sv ***
module cell_comparator_model (
   input  wire logic       clk_i,
   input  wire logic       en_i,
   input  wire logic [3:0] cond_i,
   output logic      [3:0] cmp_o
);
   timeunit 1ns;
   timeprecision 100ps;

   logic alt_q = 1'b0;

   always_ff @(posedge clk_i) begin
      alt_q <= ~alt_q;
   end

   // Unpowered comparators give a changing, meaningless level
   assign cmp_o = en_i ? cond_i : ({4{alt_q}} ^ 4'h5);
endmodule

// *** battery_protection_mode_controller_tb_top.sv ***
module battery_protection_mode_controller_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import bpm_pkg::*;

   localparam int CHG = 0, DIS = 1, SLP = 2, CEN = 3;
   logic        clk, rst_n, wake, oc, untuned, chglow, awv, wv, bre, arv, rre;
   logic [2:0]  asel;
   logic [3:0]  cond, ws;
   logic [7:0]  ovset, udset, ocset, awa, ara;
   logic [31:0] wd;
   wire  [3:0]  cmp, ow;
   wire  [5:0]  ths;
   wire         awr, wr_rdy, bv, arr, rv;
   wire  [1:0]  br, rr;
   wire  [31:0] rd;
   int          fails = 0, n_compared = 0, c;

   battery_protection_mode_controller #(.PERIOD_TICKS(50), .ON_TICKS(4), .DETECT_PER_NF(3), .RELEASE_PER_NF(2))
   battery_protection_mode_controller_inst (
      .REF_CLK_I(clk), .RESET_N_I(rst_n), .ANALOG_SEL_I(asel), .CELL_OVER_CHARGE_I(cmp[0]),
      .CELL_BELOW_OV_RELEASE_I(cmp[1]), .CELL_UNDER_DISCHARGE_I(cmp[2]), .CELL_ABOVE_UV_RELEASE_I(cmp[3]),
      .CELL_CHARGE_LOW_I(chglow), .OVERCURRENT_I(oc), .REG_UNTUNED_I(untuned), .WAKE_I(wake),
      .OVERCHARGE_DELAY_SET_I(ovset), .OVERDISCHARGE_DELAY_SET_I(udset), .OVERCURRENT_DELAY_SET_I(ocset),
      .CHARGE_FET_DRIVE_O(ow[CHG]), .DISCHARGE_FET_DRIVE_O(ow[DIS]), .SLEEP_O(ow[SLP]), .COMPARATOR_EN_O(ow[CEN]),
      .OVERCHARGE_THRESH_SEL_O(ths[1:0]), .OVERDISCHARGE_THRESH_SEL_O(ths[3:2]), .OVERCURRENT_THRESH_SEL_O(ths[5:4]),
      .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
      .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_rdy), .S_AXI_BRESP_O(br),
      .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
      .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre));

   cell_comparator_model cell_comparator_model_inst (.clk_i(clk), .en_i(ow[CEN]), .cond_i(cond), .cmp_o(cmp));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", s, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Bus step with a bound on the whole transfer
   task automatic tk(inout int n);
      @(posedge clk);
      n++;
      if (n > 60) begin
         fails++;
         $display("MISMATCH bus handshake timeout");
         conclude();
      end
   endtask

   // Bounded wait for one drive, sleep or enable output
   task automatic wt(input int k, input logic v, input int lim);
      repeat (lim) if (ow[k] !== v) @(posedge clk);
      chk($sformatf("output %0d", k), 32'(ow[k]), 32'(v));
      if (ow[k] !== v) conclude();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad, dd;
      int   n;
      ad = 1'b0;
      dd = 1'b0;
      n = 0;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      while (!(ad && dd)) begin
         tk(n);
         if (!ad && awr === 1'b1) begin
            ad = 1'b1;
            awv <= 1'b0;
         end
         if (!dd && wr_rdy === 1'b1) begin
            dd = 1'b1;
            wv <= 1'b0;
         end
      end
      do tk(n); while (bv !== 1'b1);
      // Ready stays high between calls
      chk("bresp", 32'(br), 32'(er));
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do tk(n); while (arr !== 1'b1);
      arv <= 1'b0;
      do tk(n); while (rv !== 1'b1);
      chk("rdata", rd, e);
      chk("rresp", 32'(rr), 32'(er));
   endtask

   task automatic cnt(input int n);
      c = 0;
      repeat (n) begin
         @(posedge clk);
         if (ow[CEN] === 1'b1) c++;
      end
   endtask

   initial begin
      {wake, oc, untuned, chglow, awv, wv, bre, arv, rre, rst_n} = '0;
      asel = 3'h1;
      cond = 4'h0;
      ws = 4'hF;
      ovset = 8'h02;
      udset = 8'h01;
      ocset = 8'h02;
      awa = 8'h00;
      ara = 8'h00;
      wd = 32'h0;
      cyc(4);
      rst_n <= 1'b1;
      cyc(1);
      chk("drives", 32'(ow[1:0]), 32'h0);
      rdc(ADDR_CTRL, 32'h3, RESP_OKAY);
      ws <= 4'h0;
      wr(ADDR_CTRL, 32'h0, RESP_OKAY);
      ws <= 4'hF;
      rdc(ADDR_CTRL, 32'h3, RESP_OKAY);
      chk("drives", 32'(ow[1:0]), 32'h0);
      rdc(ADDR_CFG, 32'h0, RESP_OKAY);
      rdc(ADDR_STATUS, 32'h0, RESP_OKAY);
      rdc(8'h0C, 32'h0, RESP_SLVERR);
      wr(ADDR_STATUS, 32'h7, RESP_SLVERR);
      wr(ADDR_CFG, 32'h39, RESP_OKAY);
      chk("thresh", 32'(ths), 32'h39);
      untuned <= 1'b1;
      chglow <= 1'b1;
      cyc(3);
      rdc(ADDR_STATUS, 32'h5, RESP_OKAY);
      wr(ADDR_CFG, 32'h40, RESP_OKAY);
      untuned <= 1'b0;
      cyc(3);
      rdc(ADDR_STATUS, 32'h0, RESP_OKAY);
      cnt(500);
      chk("monitor enable", 32'(c), 32'd500);
      cond <= 4'h1;
      cyc(700);
      cond <= 4'h0;
      cyc(800);
      chk("charge drive", 32'(ow[CHG]), 32'h0);
      cond <= 4'h1;
      cyc(1200);
      chk("charge drive", 32'(ow[CHG]), 32'h0);
      wt(CHG, 1'b1, 600);
      chk("discharge drive", 32'(ow[DIS]), 32'h0);
      rdc(ADDR_STATUS, 32'h4, RESP_OKAY);
      wr(ADDR_CTRL, 32'h0, RESP_OKAY);
      wt(DIS, 1'b1, 10);
      wr(ADDR_CTRL, 32'h3, RESP_OKAY);
      wt(DIS, 1'b0, 10);
      chk("charge drive", 32'(ow[CHG]), 32'h1);
      rdc(ADDR_CTRL, 32'h3, RESP_OKAY);
      cond <= 4'h2;
      wt(CHG, 1'b0, 20);
      chk("discharge drive", 32'(ow[DIS]), 32'h0);
      cond <= 4'h4;
      cyc(400);
      chk("discharge drive", 32'(ow[DIS]), 32'h0);
      wt(DIS, 1'b1, 600);
      chk("charge and sleep", 32'({ow[SLP], ow[CHG]}), 32'h3);
      rdc(ADDR_STATUS, 32'h2, RESP_OKAY);
      cond <= 4'h0;
      wake <= 1'b1;
      wt(SLP, 1'b0, 20);
      cyc(5);
      chk("drives", 32'(ow[1:0]), 32'h3);
      wr(ADDR_CTRL, 32'h1, RESP_OKAY);
      wt(CHG, 1'b0, 20);
      wr(ADDR_CTRL, 32'h3, RESP_OKAY);
      cyc(900);
      chk("discharge drive", 32'(ow[DIS]), 32'h1);
      cond <= 4'h8;
      cyc(800);
      chk("discharge drive", 32'(ow[DIS]), 32'h1);
      wr(ADDR_CTRL, 32'h3, RESP_OKAY);
      wt(DIS, 1'b0, 20);
      wake <= 1'b0;
      asel <= 3'h0;
      oc <= 1'b1;
      wt(DIS, 1'b1, 800);
      rdc(ADDR_STATUS, 32'h1, RESP_OKAY);
      oc <= 1'b0;
      wt(DIS, 1'b0, 20);
      cnt(12500);
      chk("sampled enable", 32'(c), 32'd1000);
      conclude();
   end

   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      $display("MISMATCH run timeout");
      conclude();
   end
endmodule
